// ==== clock_startup_pkg.sv ====
// Constants and types shared by the clock source start-up sequencer
package clock_startup_pkg;

  // ****************************************
  // Register word indices on the slave port
  // ****************************************
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_TRIM = 2'h1;
  localparam logic [1:0] REG_FUSES = 2'h2;

  // ****************************************
  // Status and fuse register fields
  // ****************************************
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_STATE_LSB = 1;
  localparam int STAT_FROM_RESET_BIT = 4;
  localparam int FUSE_SEL_LSB = 0;
  localparam int FUSE_STIME_LSB = 4;
  localparam int FUSE_DIV8_BIT = 6;
  localparam int FUSE_RSTDIS_BIT = 7;

  // ****************************************
  // Fuse codes, stored values (0 = programmed)
  // ****************************************
  localparam logic [3:0] SEL_RC_OSC = 4'h2;
  localparam logic [3:0] SHIPPED_SRC_SEL = 4'h2;
  localparam logic [1:0] SHIPPED_STIME = 2'h2;
  localparam logic SHIPPED_DIV8 = 1'b0;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic [1:0] STIME_RESERVED = 2'h3;

  // ****************************************
  // Start-up counts in clock cycles
  // ****************************************
  localparam int WAKE_CK_RC = 6;
  localparam int WAKE_CK_258 = 258;
  localparam int WAKE_CK_1K = 1024;
  localparam int WAKE_CK_16K = 16384;
  localparam int RESET_FIXED_CK = 14;
  localparam int WD_CYCLES_65MS = 8192;
  localparam int WD_CYCLES_4MS = 512;
  localparam int DIV8_LAST = 7;

  // ****************************************
  // Extra reset delay classes
  // ****************************************
  localparam logic [1:0] DLY_NONE = 2'h0;
  localparam logic [1:0] DLY_SHORT = 2'h1;
  localparam logic [1:0] DLY_LONG = 2'h2;

  typedef enum logic [2:0] {
    ST_START,
    ST_SRC,
    ST_FIXED,
    ST_WD,
    ST_RUN
  } seq_state_t;

endpackage

// ==== startup_down_counter.sv ====
// Loadable down counter advanced by a tick enable
`timescale 1ns/100ps
module startup_down_counter #(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  input wire logic i_tick,
  output logic o_zero
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic zero;
  } cnt_state_t;

  cnt_state_t s_r;
  cnt_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (i_load) begin
      s_nxt.count = i_load_value;
      s_nxt.zero = (i_load_value == '0);
    end else if (i_tick && (s_r.count != '0)) begin
      s_nxt.count = s_r.count - 1'b1;
      s_nxt.zero = (s_r.count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_r <= '{count: '0, zero: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_zero = s_r.zero;

endmodule

// ==== clock_source_startup_timer.sv ====
// Fuse decoded clock source selection and start-up delay sequencer
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module clock_source_startup_timer
  import clock_startup_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int WAKE_16K = WAKE_CK_16K,
  parameter int WD_LONG = WD_CYCLES_65MS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [3:0] i_clock_source_select_fuses,
  input wire logic [1:0] i_startup_time_fuses,
  input wire logic i_divide_by_eight_fuse,
  input wire logic i_reset_pin_disable_fuse,
  input wire logic i_use_shipped_fuses,
  input wire logic [7:0] i_factory_cal,
  input wire logic i_wake,
  input wire logic i_src_tick,
  input wire logic i_wd_tick,
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_cpu_hold,
  output logic o_sys_clk_en,
  output logic [7:0] o_rc_trim,
  output logic o_rc_osc_sel,
  output logic o_xtal_osc_sel,
  output logic [2:0] o_xtal_range
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [CNT_W-1:0] wake_count(input logic [3:0] sel,
                                                  input logic [1:0] stime);
    logic [CNT_W-1:0] n;
    n = CNT_W'(WAKE_CK_RC);
    if (sel[3]) begin
      if (!sel[0] && !stime[1]) begin
        n = CNT_W'(WAKE_CK_258);
      end else if (!sel[0] || (stime == 2'h0)) begin
        n = CNT_W'(WAKE_CK_1K);
      end else begin
        n = CNT_W'(WAKE_16K);
      end
    end
    return n;
  endfunction

  function automatic logic [1:0] reset_delay(input logic [3:0] sel,
                                             input logic [1:0] stime,
                                             input logic rstdis);
    logic [1:0] d;
    d = DLY_NONE;
    if (sel[3]) begin
      case ({sel[0], stime})
        3'h0: d = DLY_SHORT;
        3'h1: d = DLY_LONG;
        3'h2: d = DLY_NONE;
        3'h3: d = DLY_SHORT;
        3'h4: d = DLY_LONG;
        3'h5: d = DLY_NONE;
        3'h6: d = DLY_SHORT;
        default: d = DLY_LONG;
      endcase
    end else begin
      case (stime)
        2'h0: d = (rstdis == FUSE_PROGRAMMED) ? DLY_SHORT : DLY_NONE;
        2'h1: d = DLY_SHORT;
        2'h2: d = DLY_LONG;
        STIME_RESERVED: d = DLY_LONG; // Reserved code: take the safe, longest wait
        default: d = DLY_LONG;
      endcase
    end
    return d;
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    seq_state_t st;
    logic from_reset;
    logic hold;
    logic [2:0] div_cnt;
    logic sys_en;
    logic [7:0] trim;
    logic [3:0] sel;
    logic [1:0] stime;
    logic div8;
    logic rstdis;
    logic rc_sel;
    logic waitreq;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_tick;
  logic cnt_zero;
  logic [1:0] dly;
  logic bus_req;

  startup_down_counter #(
    .WIDTH(CNT_W)
  ) u_counter (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(cnt_load),
    .i_load_value(cnt_value),
    .i_tick(cnt_tick),
    .o_zero(cnt_zero)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    cnt_load = 1'b0;
    cnt_value = '0;
    dly = reset_delay(s_r.sel, s_r.stime, s_r.rstdis);
    bus_req = i_avs_read || i_avs_write;
    // Delay phase counts the watchdog oscillator whatever source runs
    cnt_tick = (s_r.st == ST_WD) ? i_wd_tick : i_src_tick;

    case (s_r.st)
      ST_START: begin
        cnt_load = 1'b1;
        cnt_value = wake_count(s_r.sel, s_r.stime);
        s_nxt.st = ST_SRC;
      end
      ST_SRC: begin
        if (cnt_zero && s_r.from_reset) begin
          cnt_load = 1'b1;
          cnt_value = CNT_W'(RESET_FIXED_CK);
          s_nxt.st = ST_FIXED;
        end else if (cnt_zero) begin
          s_nxt.st = ST_RUN;
        end
      end
      ST_FIXED: begin
        if (cnt_zero && (dly == DLY_NONE)) begin
          s_nxt.st = ST_RUN;
        end else if (cnt_zero) begin
          cnt_load = 1'b1;
          cnt_value = (dly == DLY_LONG) ? CNT_W'(WD_LONG)
                                        : CNT_W'(WD_CYCLES_4MS);
          s_nxt.st = ST_WD;
        end
      end
      ST_WD: begin
        if (cnt_zero) begin
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_wake) begin
          s_nxt.from_reset = 1'b0;
          s_nxt.st = ST_START;
        end
      end
      default: begin
        s_nxt.st = ST_START;
      end
    endcase
    s_nxt.hold = (s_nxt.st != ST_RUN);

    // Programmed divide fuse passes every eighth source tick
    s_nxt.sys_en = 1'b0;
    if (i_src_tick) begin
      s_nxt.div_cnt = s_r.div_cnt + 3'h1;
      if (s_r.div8 == FUSE_PROGRAMMED) begin
        s_nxt.sys_en = (s_r.div_cnt == 3'(DIV8_LAST));
      end else begin
        s_nxt.sys_en = 1'b1;
      end
    end

    // One wait cycle per access keeps the read mux off the bus path
    s_nxt.waitreq = 1'b1;
    if (bus_req && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = '0;
      case (i_avs_address)
        REG_STATUS: begin
          s_nxt.rdata[STAT_HOLD_BIT] = s_r.hold;
          s_nxt.rdata[STAT_STATE_LSB +: 3] = s_r.st;
          s_nxt.rdata[STAT_FROM_RESET_BIT] = s_r.from_reset;
        end
        REG_TRIM: s_nxt.rdata[7:0] = s_r.trim;
        REG_FUSES: begin
          s_nxt.rdata[FUSE_SEL_LSB +: 4] = s_r.sel;
          s_nxt.rdata[FUSE_STIME_LSB +: 2] = s_r.stime;
          s_nxt.rdata[FUSE_DIV8_BIT] = s_r.div8;
          s_nxt.rdata[FUSE_RSTDIS_BIT] = s_r.rstdis;
        end
        default: s_nxt.rdata = '0;
      endcase
    end
    if (i_avs_write && !s_r.waitreq && i_avs_byteenable[0]
        && (i_avs_address == REG_TRIM)) begin
      s_nxt.trim = i_avs_writedata[7:0];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_r.st <= ST_START;
      s_r.from_reset <= 1'b1;
      s_r.hold <= 1'b1;
      s_r.div_cnt <= 3'h0;
      s_r.sys_en <= 1'b0;
      s_r.trim <= i_factory_cal;
      // Fuses are sampled while reset holds, so a change is seen only on reset
      if (i_use_shipped_fuses) begin
        s_r.sel <= SHIPPED_SRC_SEL;
        s_r.stime <= SHIPPED_STIME;
        s_r.div8 <= SHIPPED_DIV8;
        s_r.rstdis <= ~FUSE_PROGRAMMED;
        s_r.rc_sel <= (SHIPPED_SRC_SEL == SEL_RC_OSC);
      end else begin
        s_r.sel <= i_clock_source_select_fuses;
        s_r.stime <= i_startup_time_fuses;
        s_r.div8 <= i_divide_by_eight_fuse;
        s_r.rstdis <= i_reset_pin_disable_fuse;
        // Decoded once here so the select output leaves a flop
        s_r.rc_sel <= (i_clock_source_select_fuses == SEL_RC_OSC);
      end
      s_r.waitreq <= 1'b1;
      s_r.rdata <= 32'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_avs_readdata = s_r.rdata;
  assign o_avs_waitrequest = s_r.waitreq;
  assign o_cpu_hold = s_r.hold;
  assign o_sys_clk_en = s_r.sys_en;
  assign o_rc_trim = s_r.trim;
  assign o_rc_osc_sel = s_r.rc_sel;
  assign o_xtal_osc_sel = s_r.sel[3];
  assign o_xtal_range = s_r.sel[3:1];

endmodule

// ==== startup_properties.sv ====
// Port checker for the clock start-up sequencer
`timescale 1ns/100ps
module startup_properties
  import clock_startup_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [3:0] i_clock_source_select_fuses,
  input wire logic i_use_shipped_fuses,
  input wire logic [7:0] i_factory_cal,
  input wire logic i_src_tick,
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic o_cpu_hold,
  input wire logic o_sys_clk_en,
  input wire logic [7:0] o_rc_trim,
  input wire logic o_rc_osc_sel,
  input wire logic o_xtal_osc_sel,
  input wire logic [2:0] o_xtal_range
);
  // ********
  // Helpers
  // ********
  logic [15:0] cnt_r;
  logic rseq_r;
  logic [3:0] sel_r;
  logic ship_r;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Src ticks seen while held, lower bound only
  always_ff @(posedge i_clock) begin
    cnt_r <= (i_rst || !o_cpu_hold) ? 16'h0 : cnt_r + 16'(i_src_tick);
    rseq_r <= i_rst || (rseq_r && o_cpu_hold);
    sel_r <= i_clock_source_select_fuses;
    ship_r <= i_use_shipped_fuses;
  end
  a_trim_load: assert property ($fell(i_rst) |-> o_rc_trim == $past(i_factory_cal))
    else $error("trim not loaded");
  a_hold_after_reset: assert property ($fell(i_rst) |-> o_cpu_hold)
    else $error("hold low after reset");
  a_trim_write: assert property (i_avs_write && !o_avs_waitrequest &&
    i_avs_address == REG_TRIM && i_avs_byteenable[0] |=>
    o_rc_trim == $past(i_avs_writedata[7:0])) else $error("trim write lost");
  a_xtal_decode: assert property ($fell(i_rst) |-> o_xtal_osc_sel == (!ship_r && sel_r[3]))
    else $error("crystal select wrong");
  a_xtal_range: assert property ($fell(i_rst) && o_xtal_osc_sel |-> o_xtal_range == sel_r[3:1])
    else $error("crystal range wrong");
  a_rc_select: assert property ($fell(i_rst) && (ship_r || sel_r == SEL_RC_OSC) |->
    o_rc_osc_sel && !o_xtal_osc_sel) else $error("rc select wrong");
  a_reset_fixed: assert property ($fell(o_cpu_hold) && rseq_r |-> cnt_r >= 16'd20)
    else $error("reset start-up too short");
  a_clk_after_tick: assert property (o_sys_clk_en |-> $past(i_src_tick))
    else $error("clock enable without tick");
  c_release: cover property ($fell(o_cpu_hold));
  c_trim_write: cover property (i_avs_write && !o_avs_waitrequest);
  c_xtal: cover property (o_xtal_osc_sel && o_xtal_range == 3'h4);
endmodule

// ==== cpu_core_model.sv ====
// CPU core model: requests wake and times each hold
`timescale 1ns/100ps
module cpu_core_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cpu_hold,
  input wire logic i_sleep_req,
  output logic o_wake,
  output logic [15:0] o_held
);
  logic prev_r = 1'b0;
  initial o_wake = 1'b0;
  initial o_held = 16'h0;
  always @(posedge i_clock) begin
    prev_r <= i_cpu_hold;
    o_wake <= i_sleep_req; // Wakes even while held, to test refusal
    if (i_rst)
      o_held <= 16'h0;
    else if (i_cpu_hold)
      o_held <= (prev_r ? o_held : 16'h0) + 16'h1; // Runs nothing while held
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the start-up sequencer
`timescale 1ns/100ps
module tb;
  import clock_startup_pkg::*;
  typedef struct packed {logic [3:0] s; logic [1:0] t; logic r; int w; int d;} row_t;
  logic i_clock = 0, i_rst = 1, i_divide_by_eight_fuse = 1, i_reset_pin_disable_fuse = 1;
  logic [3:0] i_clock_source_select_fuses = 4'h2, i_avs_byteenable = 4'h0;
  logic [1:0] i_startup_time_fuses = 2'h0, i_avs_address = 2'h0;
  logic i_use_shipped_fuses = 0, i_src_tick = 1, i_wd_tick = 0, i_avs_read = 0, i_avs_write = 0;
  logic [7:0] i_factory_cal = 8'h5a, o_rc_trim, pc;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rdat;
  logic [2:0] o_xtal_range;
  logic [15:0] held;
  logic i_wake, sleep = 0, o_avs_waitrequest, o_cpu_hold, o_sys_clk_en, o_rc_osc_sel;
  logic o_xtal_osc_sel;
  int checks = 0, bad_count = 0, cyc = 0, e;
  // Long counts shortened to keep the run brief
  row_t rows[10] = '{'{4'h8, 2'h0, 1, 258, 512}, '{4'ha, 2'h1, 1, 258, 30},
    '{4'hc, 2'h2, 1, 1024, 0}, '{4'hf, 2'h3, 1, 40, 30}, '{4'hd, 2'h1, 1, 40, 0},
    '{4'h9, 2'h0, 1, 1024, 30}, '{4'h2, 2'h0, 1, 6, 0}, '{4'h2, 2'h0, 0, 6, 512},
    '{4'h2, 2'h1, 1, 6, 512}, '{4'h2, 2'h3, 1, 6, 30}};
  clock_source_startup_timer #(.WAKE_16K(40), .WD_LONG(30)) DUT (.*);
  cpu_core_model cpu (.i_clock(i_clock), .i_rst(i_rst), .i_cpu_hold(o_cpu_hold),
    .i_sleep_req(sleep), .o_wake(i_wake), .o_held(held));
  always #12.5 i_clock = !i_clock;
  // Watchdog ticks every other cycle
  always @(posedge i_clock) begin
    i_wd_tick <= !i_wd_tick;
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] x, logic [31:0] s);
    checks++;
    if (x !== s) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic bus(logic w, logic [1:0] a, logic [31:0] d, logic [3:0] b);
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    i_avs_byteenable <= b;
    do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
    rdat = o_avs_readdata;
    i_avs_read <= 0;
    i_avs_write <= 0;
  endtask
  task automatic wait_hold(logic v);
    for (int n = 0; n < 3000 && o_cpu_hold !== v; n++) @(posedge i_clock);
  endtask
  // Wake pulse lands while held; it must not restart the count
  task automatic boot(logic [3:0] s, logic [1:0] t, logic r, logic sh);
    i_clock_source_select_fuses <= s;
    i_startup_time_fuses <= t;
    i_reset_pin_disable_fuse <= r;
    i_use_shipped_fuses <= sh;
    i_rst <= 1;
    repeat (20) @(posedge i_clock);
    i_rst <= 0;
    i_use_shipped_fuses <= 0;
    repeat (3) @(posedge i_clock);
    sleep <= 1;
    @(posedge i_clock);
    sleep <= 0;
    wait_hold(0);
  endtask
  task automatic count_en();
    pc = 0;
    repeat (64) begin
      @(posedge i_clock);
      pc = pc + 8'(o_sys_clk_en);
    end
    // Ticks stopped: no enable may appear on its own
    i_src_tick <= 0;
    repeat (3) @(posedge i_clock);
    chk("no tick", 0, o_sys_clk_en);
    i_src_tick <= 1;
  endtask
  initial begin
    foreach (rows[i]) begin
      boot(rows[i].s, rows[i].t, rows[i].r, 0);
      e = 15 + rows[i].w + 2 * rows[i].d;
      chk("reset hold", 1, 32'(held >= e && held <= e + 5));
      chk("xtal sel", rows[i].s[3], o_xtal_osc_sel);
      chk("rc sel", rows[i].s == SEL_RC_OSC, o_rc_osc_sel);
      if (rows[i].s[3])
        chk("range", rows[i].s[3:1], o_xtal_range);
      sleep <= 1;
      @(posedge i_clock);
      sleep <= 0;
      wait_hold(1);
      wait_hold(0);
      chk("wake hold", 1, 32'(held >= rows[i].w && held <= rows[i].w + 5));
    end
    count_en();
    chk("undivided", 64, pc);
    boot(4'h8, 2'h0, 1, 1);
    chk("shipped hold", 1, 32'(held >= 81 && held <= 86));
    chk("trim", 8'h5a, o_rc_trim);
    bus(0, REG_FUSES, 0, 4'hf);
    chk("fuses", 32'ha2, rdat);
    bus(0, REG_STATUS, 0, 4'hf);
    chk("status", 32'h18, rdat & 32'h1f);
    bus(1, REG_TRIM, 32'h3c, 4'h1);
    bus(1, REG_TRIM, 32'h77, 4'h0);
    bus(0, REG_TRIM, 0, 4'hf);
    chk("trim write", 32'h3c, rdat);
    bus(1, 2'h3, 32'h55, 4'hf);
    bus(0, 2'h3, 0, 4'hf);
    chk("unmapped", 0, rdat);
    i_divide_by_eight_fuse <= 0;
    boot(4'h2, 2'h0, 1, 0);
    count_en();
    chk("divided", 8, pc);
    complete_run();
  end
endmodule
bind clock_source_startup_timer startup_properties chk_i (.*);
